// file: hw/wdtsl_regs.vh
`ifndef WDTSL_REGS_VH
`define WDTSL_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register map, word aligned byte addresses
`define WDTSL_ADDR_CTRL      4'h0
`define WDTSL_ADDR_RESTART   4'h4
`define WDTSL_ADDR_STATUS    4'h8

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define WDTSL_CE_BIT         4
`define WDTSL_EN_BIT         3
`define WDTSL_PS_MSB         2
`define WDTSL_PS_LSB         0
`define WDTSL_PS_RST         3'h0

// Status register fields
`define WDTSL_FLAG_BIT       3
`define WDTSL_LVL_MSB        1
`define WDTSL_LVL_LSB        0

////////////////////////////////////////////////////////////////////////////////
// Safety levels
`define WDTSL_LVL0           2'h0
`define WDTSL_LVL1           2'h1
`define WDTSL_LVL2           2'h2

////////////////////////////////////////////////////////////////////////////////
// Timing
`define WDTSL_CLK_HZ         10000000
`define WDTSL_OSC_HZ         1000000
`define WDTSL_OSC_DIV        8'h0a
`define WDTSL_BASE_OSC_CYC   22'h004000
`define WDTSL_UNLOCK_CYC     3'h4
`define WDTSL_CNT_W          22

////////////////////////////////////////////////////////////////////////////////
// Bus encodings
`define WDTSL_HSIZE_WORD     3'h2
`define WDTSL_HTRANS_ACT_BIT 1

`endif

// file: hw/wdtsl_wd_counter.v
`timescale 1ns/1ps
`include "wdtsl_regs.vh"

// Oscillator enable divider and time-out counter
module wdtsl_wd_counter #(
   parameter [7:0]              DIV  = `WDTSL_OSC_DIV,      // System cycles per osc tick
   parameter [`WDTSL_CNT_W-1:0] BASE = `WDTSL_BASE_OSC_CYC  // Osc cycles at prescale 0
) (
   // Clock and reset
   input  wire       clock_i,
   input  wire       srst_i,
   // Control
   input  wire       run_i,
   input  wire       clear_i,
   input  wire [2:0] presc_i,
   // Event
   output reg        timeout_o
);

   localparam [7:0] DIV_LAST = DIV - 8'd1;                   // Last divider state

   reg  [7:0]              div_cnt;                          // Oscillator phase
   reg                     osc_tick;                         // One cycle per osc period
   reg  [`WDTSL_CNT_W-1:0] count;                            // Elapsed osc cycles
   wire [`WDTSL_CNT_W-1:0] limit;                            // Terminal count

   // Time-out length doubles per prescale step
   assign limit = (BASE << presc_i) - {{(`WDTSL_CNT_W-1){1'b0}}, 1'b1};

   /////////////////////////////////////////////////////////////////////////////
   // Oscillator stand-in: free running, so its phase ignores the
   // watchdog state just as a separate oscillator would
   always @(posedge clock_i) begin
      if (srst_i) begin
         div_cnt  <= 8'h00;
         osc_tick <= 1'b0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt  <= 8'h00;
         osc_tick <= 1'b1;
      end else begin
         div_cnt  <= div_cnt + 8'h01;
         osc_tick <= 1'b0;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Time-out counter, advanced only on oscillator ticks
   always @(posedge clock_i) begin
      if (srst_i || clear_i || !run_i) begin
         // Restart, disable and chip reset all start a fresh period
         count     <= {`WDTSL_CNT_W{1'b0}};
         timeout_o <= 1'b0;
      end else if (osc_tick) begin
         // At or past the end: a shorter time-out written mid-period
         // must not wait for the counter to wrap
         if (count >= limit) begin
            count     <= {`WDTSL_CNT_W{1'b0}};
            timeout_o <= 1'b1;
         end else begin
            count     <= count + {{(`WDTSL_CNT_W-1){1'b0}}, 1'b1};
            timeout_o <= 1'b0;
         end
      end else begin
         timeout_o <= 1'b0;
      end
   end

endmodule

// file: hw/wdtsl_top.v
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "wdtsl_regs.vh"

module wdtsl_top #(
   parameter [7:0]              OSC_DIV  = `WDTSL_OSC_DIV,                // Clock per osc
   parameter [`WDTSL_CNT_W-1:0] BASE_CYC = `WDTSL_BASE_OSC_CYC            // Shorten in sim
) (
   // Clock and reset
   input  wire        clock_i,
   input  wire        srst_i,
   input  wire        por_i,
   // Configuration fuses, high when programmed
   input  wire        compat_fuse_i,
   input  wire        always_on_fuse_i,
   // AHB-Lite slave
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output reg         hreadyout_o,
   output reg         hresp_o,
   output reg  [31:0] hrdata_o,
   // Watchdog state
   output reg         wd_reset_o,
   output reg         wd_enabled_o
);

   /////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Register map, one word each, upper bits read zero:
   //   control  bit 4 unlock, bit 3 enable, bits 2..0 prescale
   //   restart  any word written starts a fresh time-out period
   //   status   bit 3 watchdog reset flag, bits 1..0 safety level
   // A register write stands in for the restart instruction, so the
   // processor needs no special opcode to service the watchdog; the
   // price is that a stray store to that word also restarts it

   // Fuse synchronisers, three stages per fuse
   reg  [1:0]  fuse_s1;                    // First stage, read by stage two only
   reg  [1:0]  fuse_s2;                    // Second stage
   reg  [1:0]  fuse_s3;                    // Third stage
   reg  [1:0]  fuse_q;                     // Accepted fuse values
   wire [1:0]  fuse_raw;                   // Pins gathered for the loop
   wire        compat_fuse;                // Filtered compatibility fuse
   wire        always_on_fuse;             // Filtered always-on fuse
   reg  [1:0]  level;                      // Current safety level

   // Control state
   reg         change_unlock;              // Change window open
   reg  [2:0]  unlock_cnt;                 // Cycles left in the window
   reg         wd_enable;                  // Software enable
   reg  [2:0]  prescale_sel;               // Time-out select
   reg         wd_reset_flag;              // Sticky watchdog reset cause
   wire        wd_active;                  // Enable after level forcing

   // Next values
   reg         next_change_unlock;
   reg  [2:0]  next_unlock_cnt;
   reg         next_wd_enable;
   reg  [2:0]  next_prescale_sel;
   reg         next_wd_reset_flag;
   reg  [31:0] next_rdata;

   // Bus pipeline
   reg         dp_write;                   // Data phase is a taken write
   reg  [3:0]  dp_addr;                    // Data phase register address
   wire        ap_take;                    // Address phase accepted
   wire        ap_mapped;                  // Address inside the block
   wire        wr_ctrl;                    // Control written this cycle
   wire        wr_restart;                 // Restart command this cycle
   wire        wr_status;                  // Status written this cycle

   // Counter event
   wire        wd_timeout;                 // One-cycle time-out strobe

   /////////////////////////////////////////////////////////////////////////////
   // Fuse input synchronisers

   assign fuse_raw = {always_on_fuse_i, compat_fuse_i};

   // Fuses are static in practice; the agreement check only keeps a
   // metastable settle from ever reaching the level decode
   // Stage one is read by stage two only, never by any other logic
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_fuse
         always @(posedge clock_i) begin
            if (srst_i) begin
               fuse_s1[gi] <= 1'b0;
               fuse_s2[gi] <= 1'b0;
               fuse_s3[gi] <= 1'b0;
               fuse_q[gi]  <= 1'b0;
            end else begin
               fuse_s1[gi] <= fuse_raw[gi];
               fuse_s2[gi] <= fuse_s1[gi];
               fuse_s3[gi] <= fuse_s2[gi];
               // Accept a change once stages two and three agree
               if (fuse_s2[gi] == fuse_s3[gi]) begin
                  fuse_q[gi] <= fuse_s3[gi];
               end
            end
         end
      end
   endgenerate

   assign compat_fuse    = fuse_q[0];
   assign always_on_fuse = fuse_q[1];

   /////////////////////////////////////////////////////////////////////////////
   // Safety level decode

   // Until the synchronisers settle after reset the fuses read as
   // unprogrammed, so the block briefly behaves as level 1; fuses
   // are expected to be stable long before reset is released

   // Always-on fuse dominates the compatibility fuse
   always @* begin
      if (always_on_fuse) begin
         level = `WDTSL_LVL2;
      end else if (compat_fuse) begin
         level = `WDTSL_LVL0;
      end else begin
         level = `WDTSL_LVL1;
      end
   end

   // Level 2 forces the watchdog on regardless of the stored enable
   assign wd_active = wd_enable | (level == `WDTSL_LVL2);

   /////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase and data phase decode

   // Addresses outside the block or not word aligned read as zero
   assign ap_mapped = (haddr_i[31:4] == 28'h0000000) && (haddr_i[1:0] == 2'h0);
   assign ap_take   = hsel_i && htrans_i[`WDTSL_HTRANS_ACT_BIT] && hready_i;

   // Only word writes are taken; other sizes still get an OKAY
   always @(posedge clock_i) begin
      if (srst_i) begin
         dp_write <= 1'b0;
         dp_addr  <= 4'h0;
      end else if (hready_i) begin
         dp_write <= ap_take && hwrite_i && ap_mapped && (hsize_i == `WDTSL_HSIZE_WORD);
         dp_addr  <= haddr_i[3:0];
      end
   end

   assign wr_ctrl    = dp_write && (dp_addr == `WDTSL_ADDR_CTRL);
   assign wr_restart = dp_write && (dp_addr == `WDTSL_ADDR_RESTART);
   assign wr_status  = dp_write && (dp_addr == `WDTSL_ADDR_STATUS);

   /////////////////////////////////////////////////////////////////////////////
   // Control next-state logic

   // The window opens on the write edge and stays visible for four
   // system clocks; a second control write with unlock clear uses it
   // up at once, but a write with unlock set leaves it open, so one opening can allow two changes.
   // Level 2 takes the opening write only to time a prescale change;
   // the enable value of the second write is ignored there.

   always @* begin
      next_change_unlock = change_unlock;
      next_unlock_cnt    = unlock_cnt;
      next_wd_enable     = wd_enable;
      next_prescale_sel  = prescale_sel;
      next_wd_reset_flag = wd_reset_flag;

      // Window closes on its own after four system clocks
      if (change_unlock) begin
         if (unlock_cnt == 3'h1) begin
            next_change_unlock = 1'b0;
            next_unlock_cnt    = 3'h0;
         end else begin
            next_unlock_cnt = unlock_cnt - 3'h1;
         end
      end

      if (wr_ctrl) begin
         // Enable side: setting is always free
         if (hwdata_i[`WDTSL_EN_BIT]) begin
            next_wd_enable = 1'b1;
         end else if (change_unlock && (level != `WDTSL_LVL2)) begin
            // Disable only inside an open window, never at level 2
            next_wd_enable = 1'b0;
         end

         // Prescale side: free at level 0, windowed otherwise
         if ((level == `WDTSL_LVL0) || change_unlock) begin
            next_prescale_sel = hwdata_i[`WDTSL_PS_MSB:`WDTSL_PS_LSB];
         end

         // Opening needs unlock and enable written together
         if (hwdata_i[`WDTSL_CE_BIT] && hwdata_i[`WDTSL_EN_BIT]) begin
            next_change_unlock = 1'b1;
            next_unlock_cnt    = `WDTSL_UNLOCK_CYC;
         end else if (!hwdata_i[`WDTSL_CE_BIT]) begin
            // Second write of a sequence consumes the window
            next_change_unlock = 1'b0;
            next_unlock_cnt    = 3'h0;
         end
      end

      // Flag clears by power-on reset or by a written zero
      // Writing one to the flag has no effect
      if (por_i || (wr_status && !hwdata_i[`WDTSL_FLAG_BIT])) begin
         next_wd_reset_flag = 1'b0;
      end
      // A time-out in the clearing cycle still sets the flag
      if (wd_timeout) begin
         next_wd_reset_flag = 1'b1;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Control registers

   // Chip reset restores the start-up state; levels 0 and 1 start off
   always @(posedge clock_i) begin
      if (srst_i) begin
         change_unlock <= 1'b0;
         unlock_cnt    <= 3'h0;
         wd_enable     <= 1'b0;
         prescale_sel  <= `WDTSL_PS_RST;
      end else begin
         change_unlock <= next_change_unlock;
         unlock_cnt    <= next_unlock_cnt;
         wd_enable     <= next_wd_enable;
         prescale_sel  <= next_prescale_sel;
      end
   end

   // Reset cause must survive the reset it reports, so chip reset leaves it;
   // only power-on reset or a written zero clears it
   always @(posedge clock_i) begin
      wd_reset_flag <= next_wd_reset_flag;
   end

   /////////////////////////////////////////////////////////////////////////////
   // Read data

   // Built from next values so a read right behind a write sees it
   always @* begin
      next_rdata = 32'h00000000;
      if (ap_take && !hwrite_i && ap_mapped) begin
         case (haddr_i[3:0])
            `WDTSL_ADDR_CTRL: begin
               // Upper bits stay zero
               next_rdata[`WDTSL_CE_BIT] = next_change_unlock;
               next_rdata[`WDTSL_EN_BIT] = next_wd_enable |
                                           (level == `WDTSL_LVL2);
               next_rdata[`WDTSL_PS_MSB:`WDTSL_PS_LSB] = next_prescale_sel;
            end
            `WDTSL_ADDR_STATUS: begin
               next_rdata[`WDTSL_FLAG_BIT] = next_wd_reset_flag;
               next_rdata[`WDTSL_LVL_MSB:`WDTSL_LVL_LSB] = level;
            end
            default: begin
               // Restart and holes read as zero
               next_rdata = 32'h00000000;
            end
         endcase
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Bus outputs

   // Zero wait states and always OKAY; unmapped writes are dropped
   // Ready is low during reset so no transfer is taken while the
   // control state is being restored
   always @(posedge clock_i) begin
      if (srst_i) begin
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
         hrdata_o    <= 32'h00000000;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         if (hready_i) begin
            hrdata_o <= next_rdata;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Time-out counter

   // The terminal count is rebuilt from the current prescale, so a
   // shorter time-out written mid-period takes effect at once
   // instead of waiting for a wrap
   // Restart writes stand in for the restart instruction
   wdtsl_wd_counter #(
      .DIV  (OSC_DIV),
      .BASE (BASE_CYC)
   ) u_counter (
      .clock_i   (clock_i),
      .srst_i    (srst_i),
      .run_i     (wd_active),
      .clear_i   (wr_restart),
      .presc_i   (prescale_sel),
      .timeout_o (wd_timeout)
   );

   /////////////////////////////////////////////////////////////////////////////
   // Watchdog outputs

   // Reset request is one clock wide; the chip reset logic stretches it
   // The enabled output shows the level 2 forcing, so it can rise a
   // few clocks after reset while the fuse synchronisers settle
   always @(posedge clock_i) begin
      if (srst_i) begin
         wd_reset_o   <= 1'b0;
         wd_enabled_o <= 1'b0;
      end else begin
         wd_reset_o   <= wd_timeout;
         wd_enabled_o <= wd_active;
      end
   end

endmodule

// file: tb/wdtsl_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port checker for the watchdog top
module wdtsl_monitor (
   // Clock and reset
   input wire        clock_i,
   input wire        srst_i,
   input wire        always_on_fuse_i,
   // Bus
   input wire        hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0]  htrans_i,
   input wire        hwrite_i,
   input wire [31:0] hwdata_i,
   input wire        hready_i,
   input wire [31:0] hrdata_o,
   // Watchdog
   input wire        wd_reset_o,
   input wire        wd_enabled_o
);
   wire      acc = hsel_i && htrans_i[1] && hready_i; // Accepted address phase
   reg       wr_dp;                                   // Control write in data phase
   reg [3:0] since_ce;                                // Cycles since unlock write
   reg [3:0] lvl2_cnt;                                // Cycles settled at level 2
   // Helper state; since_ce saturates so a stale unlock never looks fresh
   always @(posedge clock_i) begin
      if (srst_i) begin
         wr_dp <= 1'b0;
         since_ce <= 4'hf;
         lvl2_cnt <= 4'h0;
      end else begin
         wr_dp <= acc && hwrite_i && haddr_i == 32'h0;
         if (wr_dp && hwdata_i[4] && hwdata_i[3]) begin
            since_ce <= 4'h0;
         end else if (since_ce != 4'hf) begin
            since_ce <= since_ce + 4'h1;
         end
         if (!always_on_fuse_i) begin
            lvl2_cnt <= 4'h0;
         end else if (lvl2_cnt != 4'h8) begin
            lvl2_cnt <= lvl2_cnt + 4'h1;
         end
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   sequence s_rd(a);
      acc && !hwrite_i && haddr_i == a;
   endsequence
   sequence s_wr(a);
      acc && hwrite_i && haddr_i == a;
   endsequence
   a_rst_clear: assert property (disable iff (1'b0) srst_i |=> !wd_enabled_o && !wd_reset_o)
      else $error("reset left watchdog active");
   a_pulse_one: assert property (wd_reset_o |=> !wd_reset_o [*8])
      else $error("reset pulse too long");
   a_restart_quiet: assert property (s_wr(32'h4) |-> ##3 !wd_reset_o [*8])
      else $error("time-out soon after restart");
   a_rsvd_zero: assert property (s_rd(32'h0) |=> hrdata_o[31:5] == 27'h0)
      else $error("reserved control bits not zero");
   a_lvl2_on: assert property (lvl2_cnt == 4'h8 |-> wd_enabled_o)
      else $error("watchdog off at level two");
   a_lvl2_read: assert property (s_rd(32'h0) ##0 lvl2_cnt == 4'h8 |=> hrdata_o[3])
      else $error("enable reads zero at level two");
   a_disable_guard: assert property ($fell(wd_enabled_o) && !$past(srst_i) |-> since_ce <= 4'h5)
      else $error("disabled without unlock");
   a_enable_write: assert property (s_wr(32'h0) ##1 hwdata_i[3] |-> ##[1:3] wd_enabled_o)
      else $error("enable write ignored");
endmodule
bind wdtsl_top wdtsl_monitor u_mon (.clock_i(clock_i), .srst_i(srst_i),
   .always_on_fuse_i(always_on_fuse_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .wd_reset_o(wd_reset_o), .wd_enabled_o(wd_enabled_o));

// file: tb/test_watchdog_timer_safety_levels.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: reads go through a queue of expected words
module test_watchdog_timer_safety_levels;
   localparam int DIV  = 2;      // Short oscillator divider
   localparam int BASE = 16;     // Short base count, keeps time-outs brief
   localparam logic [31:0] CTL = 32'h0;
   localparam logic [31:0] RST = 32'h4;
   localparam logic [31:0] STA = 32'h8;
   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        por_i = 1'b1;
   logic        compat_fuse_i = 1'b0;
   logic        always_on_fuse_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [2:0]  hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h0;
   wire         hreadyout_o;
   wire         hresp_o;
   wire  [31:0] hrdata_o;
   wire         wd_reset_o;
   wire         wd_enabled_o;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          n_pulse = 0;     // Reset pulses seen
   int          cyc_cnt = 0;     // Free cycle count
   int          t0;
   int          p0;
   logic [31:0] ps;
   logic [31:0] exp_q[$];        // Expected read words, oldest first
   logic        rd_dp = 1'b0;    // Read data phase open
   wdtsl_top #(.OSC_DIV(8'(DIV)), .BASE_CYC(22'(BASE))) DUT (.clock_i(clock_i),
      .srst_i(srst_i), .por_i(por_i), .compat_fuse_i(compat_fuse_i),
      .always_on_fuse_i(always_on_fuse_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .hrdata_o(hrdata_o), .wd_reset_o(wd_reset_o), .wd_enabled_o(wd_enabled_o));
   always #50 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Watcher: read data is taken at the edge closing the data phase
   always @(posedge clock_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (wd_reset_o === 1'b1) begin
         n_pulse <= n_pulse + 1;
      end
      if (rd_dp && hreadyout_o === 1'b1) begin
         check(hrdata_o, exp_q.pop_front());
         check(32'(hresp_o), 32'h0);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // One single transfer; the address phase holds until hready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] e);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      haddr_i <= a;
      @(posedge clock_i);
      while (hreadyout_o !== 1'b1) @(posedge clock_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      rd_dp <= !w;
      if (!w) exp_q.push_back(e);
      @(posedge clock_i);
      while (hreadyout_o !== 1'b1) @(posedge clock_i);
      rd_dp <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // Fuses only change under reset, as they would at power-up
   // Power-on reset is optional so the cause flag can be seen to survive
   task automatic chip_reset(input logic cf, input logic af, input logic p);
      srst_i <= 1'b1;
      por_i <= p;
      compat_fuse_i <= cf;
      always_on_fuse_i <= af;
      cyc(6);
      srst_i <= 1'b0;
      por_i <= 1'b0;
      cyc(8);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      ps = $urandom(38);
      chip_reset(1'b0, 1'b0, 1'b1);
      rd(CTL, 32'h0);
      rd(STA, 32'h1);
      rd(32'hc, 32'h0);
      wr(CTL, 32'h08);
      rd(CTL, 32'h08);
      wr(CTL, 32'h00);
      rd(CTL, 32'h08);
      wr(CTL, 32'h0b);
      rd(CTL, 32'h08);
      wr(CTL, 32'h18);
      wr(CTL, 32'h0a);
      rd(CTL, 32'h0a);
      wr(CTL, 32'h18);
      cyc(4);
      wr(CTL, 32'h00);
      rd(CTL, 32'h0a);
      wr(CTL, 32'h18);
      wr(CTL, 32'h00);
      rd(CTL, 32'h00);
      wr(CTL, 32'he8);
      rd(CTL, 32'h08);
      // Level 0: free prescale, guarded disable, real time-out
      chip_reset(1'b1, 1'b0, 1'b1);
      ps = $urandom % 2;
      rd(CTL, 32'h0);
      wr(CTL, ps);
      rd(CTL, ps);
      wr(CTL, ps | 32'h08);
      p0 = n_pulse;
      repeat (6) begin
         cyc(4);
         wr(RST, 32'h0);
      end
      check(n_pulse - p0, 32'h0);
      t0 = cyc_cnt;
      while (n_pulse == p0 && cyc_cnt - t0 < 1000) @(posedge clock_i);
      t0 = cyc_cnt - t0 - (BASE << ps) * DIV;
      check(32'(t0 >= -3 && t0 <= DIV + 4), 32'h1);
      rd(STA, 32'h8);
      wr(STA, 32'h0);
      rd(STA, 32'h0);
      wr(CTL, ps);
      rd(CTL, ps | 32'h08);
      wr(CTL, ps | 32'h18);
      wr(CTL, ps);
      p0 = n_pulse;
      cyc(300);
      check(n_pulse - p0, 32'h0);
      // Level 2 with a random compatibility fuse
      chip_reset(1'($urandom % 2), 1'b1, 1'b1);
      rd(CTL, 32'h08);
      rd(STA, 32'h2);
      wr(CTL, 32'h18);
      wr(CTL, 32'h03);
      rd(CTL, 32'h0b);
      wr(CTL, 32'h18);
      wr(CTL, 32'h00);
      rd(CTL, 32'h08);
      wr(CTL, 32'h05);
      rd(CTL, 32'h08);
      check(32'(wd_enabled_o), 32'h1);
      // Level 2 cannot be stopped: its time-out must come, and a chip
      // reset without power-on reset must keep the cause flag
      p0 = n_pulse;
      t0 = cyc_cnt;
      while (n_pulse == p0 && cyc_cnt - t0 < 1000) @(posedge clock_i);
      check(32'(n_pulse - p0), 32'h1);
      chip_reset(1'b0, 1'b1, 1'b0);
      rd(STA, 32'ha);
      cyc(2);
      finish_test();
   end
   // Hang guard
   initial begin
      cyc(20000);
      n_mismatch++;
      finish_test();
   end
endmodule
